// File: verilog/qec_defines.svh
// qec_defines.svh: reset values and mode codes for the quadrature encoder counter
// assumes inclusion by bare name from the package and the counter module
`ifndef QEC_DEFINES_SVH
`define QEC_DEFINES_SVH
`define QEC_CNT_W 16
`define QEC_MAX_RESET 16'h0FFF
`define QEC_MODE_FREE 2'h0
`define QEC_MODE_FREE_CAPTURE 2'h1
`define QEC_MODE_RESET_INDEX 2'h2
`define QEC_MODE_FIRST_INDEX 2'h3
`endif

// File: verilog/qec_pkg.sv
// qec_pkg.sv: types shared by the quadrature encoder counter
// assumes qec_defines.svh on the include path
`include "qec_defines.svh"
package qec_pkg;
  typedef enum logic [1:0] {
    QEC_FREE = `QEC_MODE_FREE,
    QEC_FREE_CAPTURE = `QEC_MODE_FREE_CAPTURE,
    QEC_RESET_INDEX = `QEC_MODE_RESET_INDEX,
    QEC_FIRST_INDEX = `QEC_MODE_FIRST_INDEX
  } qec_mode_t;
  // raw encoder channels after polarity
  typedef struct packed {
    logic chan_a;
    logic chan_b;
    logic index;
  } qec_enc_t;
  // index init state, gray along waiting -> armed-done
  typedef enum logic [1:0] {
    QEC_WAIT_INDEX = 2'h0,
    QEC_INIT_DONE = 2'h1
  } qec_init_t;
endpackage

// File: verilog/qec_counter.sv
// qec_counter.sv: quadrature decoder and wrapping position counter with index handling
// assumes encoder pins arrive asynchronous to clk_sys and config ports are held static
//
// Function
// - count up when B rising edge lags A rising edge, down when reversed
// - every single-channel edge of A and B changes count by one, four per line pair; simultaneous A and B edges are dropped
// - at maximum, a forward edge loads zero
// - at zero, a reverse edge loads maximum
// - rising index edge clears counter when mode asks for it
// - free running clears only on wrap; no index or capture output
// - capture mode clears on wrap only and latches count at each index
// - reset-by-index clears on every index; no capture output
// - first-index mode clears only on first index after start
// - outputs: live count, index pulse, count captured at previous index
// - decoder runs standard quadrature, A on input 0, B on input 1
// - per-channel polarity picks rising or falling as pulse start; index polarity is ignored with direct routing
// - index routed to decoder input 2 or directly to counter slice
// - explicit slice selection only with direct index routing
`timescale 1ns/1ps
`include "qec_defines.svh"
module qec_counter #(
  parameter int CNT_W = `QEC_CNT_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [2:0] enc_in,
  input wire logic [2:0] enc_invert,
  input wire logic [CNT_W-1:0] max_count,
  input wire qec_pkg::qec_mode_t mode,
  input wire logic index_direct,
  input wire logic slice_sel_req,
  output logic [CNT_W-1:0] count_reg,
  output logic index_pulse_reg,
  output logic [CNT_W-1:0] index_latched_count_reg,
  output logic slice_sel_ok_reg
);
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  qec_pkg::qec_enc_t enc_reg;
  qec_pkg::qec_enc_t enc_next;
  qec_pkg::qec_init_t init_reg;
  logic [CNT_W-1:0] count_next;
  logic step_up;
  logic step_dn;
  logic index_rise;
  logic index_clear;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= enc_in;
      sync2_reg <= sync1_reg;
    end
  end

  // polarity: falling-edge start simply inverts the channel
  always_comb begin
    enc_next.chan_a = sync2_reg[0] ^ enc_invert[0];
    enc_next.chan_b = sync2_reg[1] ^ enc_invert[1];
    // direct routing bypasses decoder polarity, slice sees raw rising edge
    enc_next.index = index_direct ? sync2_reg[2] : (sync2_reg[2] ^ enc_invert[2]);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      enc_reg <= '0;
    end else begin
      enc_next_hold: enc_reg <= enc_next;
    end
  end

  // x1 = a^b; a change of exactly one channel gives direction
  always_comb begin
    logic a_chg;
    logic b_chg;
    a_chg = enc_next.chan_a ^ enc_reg.chan_a;
    b_chg = enc_next.chan_b ^ enc_reg.chan_b;
    // both changing at once is an illegal jump, dropped
    // forward order ab: 00, 10, 11, 01; new a differs from old b on every forward step
    step_up = (a_chg ^ b_chg) & (enc_next.chan_a ^ enc_reg.chan_b) & ~(a_chg & b_chg);
    step_dn = (a_chg ^ b_chg) & ~(enc_next.chan_a ^ enc_reg.chan_b) & ~(a_chg & b_chg);
    index_rise = enc_next.index & ~enc_reg.index;
  end

  always_comb begin
    case (mode)
      qec_pkg::QEC_RESET_INDEX: index_clear = index_rise;
      qec_pkg::QEC_FIRST_INDEX: index_clear = index_rise && init_reg == qec_pkg::QEC_WAIT_INDEX;
      default: index_clear = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      init_reg <= qec_pkg::QEC_WAIT_INDEX;
    end else begin
      case (init_reg)
        qec_pkg::QEC_WAIT_INDEX: if (index_clear) init_reg <= qec_pkg::QEC_INIT_DONE;
        qec_pkg::QEC_INIT_DONE: init_reg <= qec_pkg::QEC_INIT_DONE;
        default: init_reg <= qec_pkg::QEC_WAIT_INDEX;
      endcase
    end
  end

  // index clear has priority over a same-cycle step
  always_comb begin
    count_next = count_reg;
    if (index_clear) begin
      count_next = '0;
    end else if (step_up) begin
      count_next = (count_reg >= max_count) ? '0 : count_reg + 1'b1;
    end else if (step_dn) begin
      count_next = (count_reg == '0) ? max_count : count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // index pulse exists in every mode except plain free running
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      index_pulse_reg <= 1'b0;
    end else begin
      index_pulse_reg <= index_rise && mode != qec_pkg::QEC_FREE;
    end
  end

  // capture holds the count just before the index edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      index_latched_count_reg <= '0;
    end else if (mode != qec_pkg::QEC_FREE_CAPTURE) begin
      index_latched_count_reg <= '0;
    end else if (index_rise) begin
      index_latched_count_reg <= count_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      slice_sel_ok_reg <= 1'b0;
    end else begin
      slice_sel_ok_reg <= slice_sel_req & index_direct;
    end
  end
endmodule

// File: verification/qec_enc_model.sv
// qec_enc_model.sv: behavioural encoder, gray-coded A and B plus index
// assumes one step code per clk_sys edge from the bench
`timescale 1ns/1ps
module qec_enc_model (
  input wire logic clk_sys,
  input wire logic [1:0] step,
  input wire logic index,
  output logic [2:0] enc_in
);
  logic [1:0] phase_reg = 2'h0;
  // code 1 forward, 2 both channels at once, 3 reverse
  always_ff @(posedge clk_sys) begin
    phase_reg <= phase_reg + step;
  end
  // a leads b on forward steps
  assign enc_in = {index, phase_reg[1], phase_reg[1] ^ phase_reg[0]};
endmodule

// File: verification/qec_counter_properties.sv
// qec_counter_properties.sv: port checks for qec_counter
// assumes mode and routing change only while reset is held
`timescale 1ns/1ps
module qec_counter_properties #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [CNT_W-1:0] max_count,
  input wire qec_pkg::qec_mode_t mode,
  input wire logic index_direct,
  input wire logic slice_sel_req,
  input wire logic [CNT_W-1:0] count_reg,
  input wire logic index_pulse_reg,
  input wire logic [CNT_W-1:0] index_latched_count_reg,
  input wire logic slice_sel_ok_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_slice_sel_ok: assert property ($past(reset_n) |-> slice_sel_ok_reg == $past(slice_sel_req & index_direct))
    else $error("slice grant");
  a_pulse_one_cycle: assert property (index_pulse_reg |=> !index_pulse_reg) else $error("pulse width");
  a_free_no_pulse: assert property (mode == 2'h0 |-> !index_pulse_reg) else $error("free pulse");
  a_capture_mode_only: assert property (mode != 2'h1 |-> index_latched_count_reg == 0) else $error("latch");
  a_capture_value: assert property (index_pulse_reg && mode == 2'h1 |-> index_latched_count_reg == $past(count_reg))
    else $error("latch value");
  a_latch_hold: assert property ($past(reset_n) && !index_pulse_reg |-> $stable(index_latched_count_reg))
    else $error("latch hold");
  a_index_clear: assert property (index_pulse_reg && mode == 2'h2 |-> count_reg == 0) else $error("clear");
  a_step_by_one: assert property ($past(reset_n) && !index_pulse_reg && count_reg != $past(count_reg) |->
    count_reg == $past(count_reg) + 1'b1 || count_reg == $past(count_reg) - 1'b1 || count_reg == 0 ||
    count_reg == max_count) else $error("step");
endmodule
bind qec_counter qec_counter_properties #(.CNT_W(CNT_W)) u_props (.clk_sys, .reset_n, .max_count, .mode,
  .index_direct, .slice_sel_req, .count_reg, .index_pulse_reg, .index_latched_count_reg, .slice_sel_ok_reg);

// File: verification/tb.sv
// tb.sv: self-checking bench for qec_counter driven by an encoder model
// assumes qec_pkg and qec_enc_model are compiled first
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, index = 1'b0, index_direct = 1'b0, slice_sel_req = 1'b0;
  logic [1:0] step = 2'h0;
  logic [2:0] enc_in, enc_invert = 3'h0;
  logic [15:0] max_count = 16'h0007;
  qec_pkg::qec_mode_t mode = qec_pkg::QEC_FREE;
  logic [15:0] count_reg, index_latched_count_reg;
  logic index_pulse_reg, slice_sel_ok_reg;
  int bad_count = 0, checked = 0, seen;
  int rows[6][2] = '{'{-1, 7}, '{1, 0}, '{7, 7}, '{1, 0}, '{-3, 5}, '{2, 7}};
  always #10 clk_sys = ~clk_sys;
  qec_enc_model enc (.clk_sys, .step, .index, .enc_in);
  qec_counter uut (.clk_sys, .reset_n, .enc_in, .enc_invert, .max_count, .mode, .index_direct, .slice_sel_req,
    .count_reg, .index_pulse_reg, .index_latched_count_reg, .slice_sel_ok_reg);
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    #1 checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // steps spaced wide so every edge clears the sync pipeline
  task automatic move(input int n, input logic [1:0] code);
    repeat (n) begin
      @(posedge clk_sys) step <= code;
      @(posedge clk_sys) step <= 2'h0;
      repeat (5) @(posedge clk_sys);
    end
  endtask
  task automatic restart(input logic [1:0] m, input logic [2:0] inv);
    // park both lines low so the pipeline reset state matches the pins
    for (int i = 0; i < 4 && enc_in[1:0] != 2'h0; i++) move(1, 2'h1);
    @(posedge clk_sys) reset_n <= 1'b0;
    mode <= qec_pkg::qec_mode_t'(m);
    index_direct <= m[0];
    enc_invert <= inv;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("reset", count_reg, 16'h0000);
  endtask
  task automatic kick(output int n);
    n = 0;
    @(posedge clk_sys) index <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys) index <= i < 3;
      #1 n += (index_pulse_reg === 1'b1);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d of %0d checks", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    restart(2'h0, 3'h0);
    for (int r = 0; r < 6; r++) begin
      move(rows[r][0] < 0 ? -rows[r][0] : rows[r][0], rows[r][0] < 0 ? 2'h3 : 2'h1);
      check("row", count_reg, 16'(rows[r][1]));
    end
    move(2, 2'h2);
    check("both", count_reg, 16'h0007);
    for (int m = 0; m < 4; m++) begin
      restart(m[1:0], 3'h0);
      move(3, 2'h1);
      kick(seen);
      check("pulse", 16'(seen), 16'(m != 0));
      check("idx1", count_reg, m < 2 ? 16'h0003 : 16'h0000);
      move(2, 2'h1);
      kick(seen);
      check("idx2", count_reg, m < 2 ? 16'h0005 : m == 2 ? 16'h0000 : 16'h0002);
      check("latch", index_latched_count_reg, m == 1 ? 16'h0005 : 16'h0000);
    end
    // park at phase zero so inverting both lines flips them together
    move(1, 2'h1);
    restart(2'h0, 3'h3);
    move(1, 2'h3);
    check("invert", count_reg, 16'h0007);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys) {index_direct, slice_sel_req} <= k[1:0];
      repeat (2) @(posedge clk_sys);
      check("slice", slice_sel_ok_reg, 16'(k == 3));
    end
    close_out();
  end
endmodule
